// file: bench/csm_core_assertions.sv
// assertion checker of the core status block
`timescale 1ns/1ps
`include "csm_regs.svh"
module csm_core_checker
  import csm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire csm_pkg::csm_instr_t instr,
  input wire logic instrValid,
  input wire csm_pkg::csm_sys_t sysEv,
  input wire logic [8:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic [7:0] accOut,
  input wire logic [7:0] flagsOut,
  input wire csm_pkg::csm_mem_wr_t memWr,
  input wire logic [7:0] branchLow,
  input wire logic branchTaken,
  input wire logic dummyCycle,
  input wire logic optMapActive
);
  logic secondSeen;

  // ****************************************
  // helper logic
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      secondSeen <= 1'b0;
    else
      secondSeen <= regWr && regAddr == `CSM_ADDR_UNLOCK && regWrData == `CSM_UNLOCK_SECOND;
  end

  // ****************************************
  // sequences and assertions
  // ****************************************
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence unlockFirst;
    regWr && regAddr == `CSM_ADDR_UNLOCK && regWrData == `CSM_UNLOCK_FIRST;
  endsequence
  sequence unlockSecond;
    regWr && regAddr == `CSM_ADDR_UNLOCK && regWrData == `CSM_UNLOCK_SECOND;
  endsequence
  sequence wakeThenRead;
    sysEv.wake ##1 !regWr ##1 (regRd && regAddr == `CSM_ADDR_UNLOCK);
  endsequence

  chk_unlock_open: assert property (unlockFirst ##1 unlockSecond |=> optMapActive)
    else $error("map not opened after pattern");
  chk_open_cause: assert property ($rose(optMapActive) |-> secondSeen)
    else $error("map opened without pattern");
  chk_branch_jump: assert property (regWr && regAddr == `CSM_ADDR_BRANCH_LOW
    |=> branchTaken && branchLow == $past(regWrData))
    else $error("branch not taken on low byte write");
  chk_dummy_slot: assert property (branchTaken |=> dummyCycle)
    else $error("no dummy cycle after branch");
  chk_move_route: assert property (instrValid && instr.op == CSM_OP_MOVA
    |=> memWr.valid && memWr.addr == $past(instr.addr) && memWr.data == $past(accOut))
    else $error("move did not carry accumulator");
  chk_halt_flags: assert property (sysEv.halt && !sysEv.wdTimeout && !sysEv.wdKick
    |=> flagsOut[`CSM_F_PDOWN] && !flagsOut[`CSM_F_WDEXP])
    else $error("halt flags wrong");
  chk_kick_flags: assert property (sysEv.wdKick && !sysEv.wdTimeout && !sysEv.halt
    |=> !flagsOut[`CSM_F_PDOWN] && !flagsOut[`CSM_F_WDEXP])
    else $error("kick flags wrong");
  chk_expiry_set: assert property (sysEv.wdTimeout |=> flagsOut[`CSM_F_WDEXP])
    else $error("expiry flag not set");
  chk_sys_hold: assert property (!(sysEv.halt || sysEv.wdKick || sysEv.wdTimeout)
    |=> $stable(flagsOut[`CSM_F_WDEXP:`CSM_F_PDOWN]))
    else $error("system flags changed without event");
  chk_wake_clear: assert property (wakeThenRead |=> regRdData == `CSM_RST_BYTE)
    else $error("unlock register not cleared by wake");
endmodule : csm_core_checker

bind csm_core csm_core_checker csm_core_checker_i
(
  .clk,
  .rst_n,
  .instr,
  .instrValid,
  .sysEv,
  .regAddr,
  .regWrData,
  .regWr,
  .regRd,
  .regRdData,
  .accOut,
  .flagsOut,
  .memWr,
  .branchLow,
  .branchTaken,
  .dummyCycle,
  .optMapActive
);

// file: bench/csm_core_tb_top.sv
// self-checking bench of the core status block
`timescale 1ns/1ps
`include "csm_regs.svh"
module csm_core_tb_top;
  import csm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  csm_instr_t instr = '0;
  logic instrValid = 1'b0;
  csm_sys_t sysEv = '0;
  logic [8:0] regAddr = '0;
  logic [7:0] regWrData = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] memRdData, regRdData, accOut, flagsOut, branchLow;
  logic [15:0] progWord;
  logic [13:0] optWord;
  logic [11:0] tablePtr;
  csm_mem_wr_t memWr;
  logic slowOsc, branchTaken, dummyCycle, optMapActive;
  logic [1:0] sectorSel;
  int fails = 0;
  int cmpCount = 0;

  always #12.5 clk = ~clk;

  csm_core csm_core_i (.clk, .rst_n, .instr, .instrValid, .memRdData, .progWord, .optWord, .sysEv,
    .slowOsc, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .accOut, .flagsOut, .tablePtr,
    .memWr, .branchLow, .branchTaken, .dummyCycle, .optMapActive, .sectorSel);
  csm_far_model csm_far_model_i (.clk, .tablePtr, .progWord, .optWord, .memRdData, .slowOsc);

  // ****************************************
  // drivers and compare
  // ****************************************
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask : wr

  task wrs(input logic [7:0] d0, input logic [7:0] d1);
    @(posedge clk);
    regAddr <= `CSM_ADDR_UNLOCK;
    regWrData <= d0;
    regWr <= 1'b1;
    @(posedge clk);
    regWrData <= d1;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask : wrs

  task rd(input logic [8:0] a, input logic [7:0] e, input string what);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    check(what, regRdData, e);
  endtask : rd

  task exec(input csm_op_t op, input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    instr <= '{op, a, d};
    instrValid <= 1'b1;
    @(posedge clk);
    instrValid <= 1'b0;
    #1;
  endtask : exec

  task pulse(input csm_sys_t s);
    @(posedge clk);
    sysEv <= s;
    @(posedge clk);
    sysEv <= '0;
    #1;
  endtask : pulse

  // ****************************************
  // scenarios
  // ****************************************
  task t_alu;
    csm_op_t ops [10] = '{CSM_OP_ADD, CSM_OP_SUB, CSM_OP_OR, CSM_OP_SBC, CSM_OP_SBC, CSM_OP_RLC,
      CSM_OP_ADC, CSM_OP_XOR, CSM_OP_AND, CSM_OP_RRC};
    logic [7:0] opd [10] = '{8'h88, 8'h10, 8'h80, 8'h80, 8'h01, 8'h00, 8'h01, 8'hA5, 8'h0F, 8'h00};
    logic [7:0] acc [10] = '{8'h10, 8'h00, 8'h80, 8'h00, 8'hFF, 8'hFE, 8'h00, 8'hA5, 8'h05, 8'h82};
    logic [7:0] flg [10] = '{8'h8B, 8'h47, 8'hC3, 8'h47, 8'h80, 8'h81, 8'h07, 8'h83, 8'h03, 8'h03};
    exec(CSM_OP_LOADA, 9'h000, 8'h88);
    check("acc load", accOut, 8'h88);
    for (int i = 0; i < 10; i++)
    begin
      exec(ops[i], 9'h000, opd[i]);
      check("acc", accOut, acc[i]);
      check("flags", flagsOut, flg[i]);
    end
    rd(`CSM_ADDR_ACC, 8'h82, "acc read");
  endtask : t_alu

  task t_move;
    exec(CSM_OP_MOVM, 9'h0F0, 8'h00);
    check("mem load", accOut, 8'hC3);
    check("sector zero", 8'(sectorSel), 8'h00);
    exec(CSM_OP_LOADA, 9'h000, 8'h5A);
    exec(CSM_OP_MOVA, 9'h1F0, 8'h00);
    check("move valid", 8'(memWr.valid), 8'h01);
    check("move data", memWr.data, 8'h5A);
    check("move offset", memWr.addr[7:0], 8'hF0);
    check("sector", 8'(sectorSel), 8'h01);
  endtask : t_move

  task t_sys;
    wr(`CSM_ADDR_FLAGS, 8'hFF);
    rd(`CSM_ADDR_FLAGS, 8'hCF, "flags write");
    pulse(4'b0010);
    check("halt", flagsOut, 8'hDF);
    pulse(4'b1000);
    check("expiry", flagsOut, 8'hFF);
    wr(`CSM_ADDR_FLAGS, 8'h00);
    check("flags clear", flagsOut, 8'h30);
    pulse(4'b0010);
    check("halt again", flagsOut, 8'h10);
    pulse(4'b0100);
    check("kick", flagsOut, 8'h00);
  endtask : t_sys

  task t_branch;
    wr(`CSM_ADDR_BRANCH_LOW, 8'h3C);
    check("branch", 8'(branchTaken), 8'h01);
    check("branch low", branchLow, 8'h3C);
    @(posedge clk);
    #1;
    check("dummy", 8'(dummyCycle), 8'h01);
  endtask : t_branch

  task t_bad;
    wrs(8'h55, 8'h12);
    wr(`CSM_ADDR_UNLOCK, 8'hAA);
    wr(`CSM_ADDR_UNLOCK, 8'h55);
    wr(`CSM_ADDR_UNLOCK, 8'hAA);
    @(posedge clk);
    #1;
    check("map shut", 8'(optMapActive), 8'h00);
  endtask : t_bad

  task t_table;
    wr(`CSM_ADDR_TBL_PTR_LOW, 8'h12);
    wr(`CSM_ADDR_TBL_PTR_HIGH, 8'h03);
    exec(CSM_OP_TABLE_READ_OP, 9'h030, 8'h00);
    check("table low", memWr.data, 8'h12);
    rd(`CSM_ADDR_TBL_RES_HIGH, 8'h31, "table high");
    wr(`CSM_ADDR_TBL_PTR_LOW, 8'hC5);
    wr(`CSM_ADDR_TBL_PTR_HIGH, 8'h0F);
    wrs(8'h55, 8'hAA);
    check("table ptr", 8'(tablePtr[11:4]), 8'hFC);
    exec(CSM_OP_TABLE_READ_OP, 9'h031, 8'h00);
    check("option low", memWr.data, 8'h85);
    rd(`CSM_ADDR_TBL_RES_HIGH, 8'h06, "option high");
    exec(CSM_OP_TABLE_READ_LASTPAGE_OP, 9'h032, 8'h00);
    check("option last page", memWr.data, 8'h85);
  endtask : t_table

  task t_window;
    int n;
    n = 0;
    wrs(8'h55, 8'hAA);
    repeat (16) @(posedge clk);
    wrs(8'h55, 8'hAA);
    while (optMapActive === 1'b1 && n < 60)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check("window", 8'(n >= 24 && n <= 40), 8'h01);
    exec(CSM_OP_TABLE_READ_OP, 9'h033, 8'h00);
    check("closed low", memWr.data, 8'hC5);
    rd(`CSM_ADDR_TBL_RES_HIGH, 8'hFC, "closed high");
  endtask : t_window

  task t_wake;
    wr(`CSM_ADDR_UNLOCK, 8'h5A);
    rd(`CSM_ADDR_UNLOCK, 8'h5A, "unlock rw");
    pulse(4'b0001);
    rd(`CSM_ADDR_UNLOCK, 8'h00, "unlock wake");
  endtask : t_wake

  // ****************************************
  // verdict and sequence
  // ****************************************
  task end_of_test;
    if (fails == 0 && cmpCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    end_of_test;
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(`CSM_ADDR_FLAGS, 8'h00, "flags reset");
    rd(9'h000, 8'h00, "unmapped");
    t_alu;
    t_move;
    t_sys;
    t_branch;
    t_bad;
    t_table;
    t_window;
    t_wake;
    end_of_test;
  end
endmodule : csm_core_tb_top

// file: bench/csm_far_model.sv
// program, option memory and slow oscillator model
`timescale 1ns/1ps
module csm_far_model #(
  parameter int SLOW_HALF = 4
) (
  input wire logic clk,
  input wire logic [11:0] tablePtr,
  output logic [15:0] progWord,
  output logic [13:0] optWord,
  output logic [7:0] memRdData,
  output logic slowOsc
);
  int cnt = 0;
  logic osc = 1'b0;

  // ****************************************
  // memories
  // ****************************************
  assign progWord = {tablePtr[11:4], tablePtr[7:0]};
  assign optWord = {tablePtr[5:0] + 6'h01, 2'b10, tablePtr[5:0]};
  assign memRdData = 8'hC3;

  // ****************************************
  // slow oscillator
  // ****************************************
  always @(posedge clk)
  begin
    if (cnt == SLOW_HALF - 1)
    begin
      cnt <= 0;
      osc <= ~osc;
    end
    else
      cnt <= cnt + 1;
  end
  assign slowOsc = osc;
endmodule : csm_far_model

// file: core/csm_core.sv
// accumulator, flags, table and option map logic of the core
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "csm_regs.svh"

module csm_core #(
  parameter int PAGE_BITS = 4,
  parameter logic [2:0] WINDOW_TICKS = `CSM_WINDOW_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire csm_pkg::csm_instr_t instr,
  input wire logic instrValid,
  input wire logic [7:0] memRdData,
  input wire logic [15:0] progWord,
  input wire logic [13:0] optWord,
  input wire csm_pkg::csm_sys_t sysEv,
  input wire logic slowOsc,
  input wire logic [8:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  output logic [7:0] accOut,
  output logic [7:0] flagsOut,
  output logic [PAGE_BITS+7:0] tablePtr,
  output csm_pkg::csm_mem_wr_t memWr,
  output logic [7:0] branchLow,
  output logic branchTaken,
  output logic dummyCycle,
  output logic optMapActive,
  output logic [1:0] sectorSel
);
  import csm_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [7:0] acc_reg;
  logic [7:0] flags_reg;
  logic [7:0] ptrLow_reg;
  logic [7:0] ptrHigh_reg;
  logic [7:0] resHigh_reg;
  logic [7:0] unlock_reg;
  logic [7:0] branch_reg;
  logic branchTaken_reg;
  logic dummy_reg;
  logic [7:0] rdData_reg;
  csm_mem_wr_t memWr_reg;
  logic [1:0] sector_reg;
  logic [2:0] tick_reg;
  logic mapOn_reg;
  logic oscSync1_reg;
  logic oscSync2_reg;
  logic oscPrev_reg;

  typedef enum logic [0:0]
  {
    CSM_UL_IDLE = 1'b0,
    CSM_UL_GOT55 = 1'b1
  } csm_ul_t;
  csm_ul_t ulState_reg;

  // ****************************************
  // alu
  // ****************************************
  logic [7:0] aluRes;
  logic aluCarry;
  logic aluHalf;
  logic aluWrap;
  logic aluArith;
  logic aluLogic;
  logic [7:0] opB;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] sum7;
  logic cin;

  function automatic logic isFlagAddr(input logic [8:0] a);
    isFlagAddr = (a == `CSM_ADDR_FLAGS);
  endfunction : isFlagAddr

  always_comb
  begin
    opB = instr.operand;
    cin = 1'b0;
    aluRes = acc_reg;
    aluCarry = flags_reg[`CSM_F_CARRY];
    aluHalf = flags_reg[`CSM_F_HALF];
    aluWrap = flags_reg[`CSM_F_WRAP];
    aluArith = 1'b0;
    aluLogic = 1'b0;
    case (instr.op)
      CSM_OP_ADC: cin = flags_reg[`CSM_F_CARRY];
      CSM_OP_SUB:
      begin
        opB = ~instr.operand;
        cin = 1'b1;
      end
      CSM_OP_SBC:
      begin
        opB = ~instr.operand;
        cin = flags_reg[`CSM_F_CARRY];
      end
      default: cin = 1'b0;
    endcase
    sum9 = {1'b0, acc_reg} + {1'b0, opB} + {8'h00, cin};
    sum5 = {1'b0, acc_reg[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
    sum7 = {1'b0, acc_reg[6:0]} + {1'b0, opB[6:0]} + {7'h00, cin};
    case (instr.op)
      CSM_OP_ADD, CSM_OP_ADC, CSM_OP_SUB, CSM_OP_SBC:
      begin
        aluRes = sum9[7:0];
        aluCarry = sum9[8];
        aluHalf = sum5[4];
        aluWrap = sum7[7] ^ sum9[8];
        aluArith = 1'b1;
      end
      CSM_OP_AND:
      begin
        aluRes = acc_reg & instr.operand;
        aluLogic = 1'b1;
      end
      CSM_OP_OR:
      begin
        aluRes = acc_reg | instr.operand;
        aluLogic = 1'b1;
      end
      CSM_OP_XOR:
      begin
        aluRes = acc_reg ^ instr.operand;
        aluLogic = 1'b1;
      end
      CSM_OP_RLC:
      begin
        aluRes = {acc_reg[6:0], flags_reg[`CSM_F_CARRY]};
        aluCarry = acc_reg[7];
      end
      CSM_OP_RRC:
      begin
        aluRes = {flags_reg[`CSM_F_CARRY], acc_reg[7:1]};
        aluCarry = acc_reg[0];
      end
      CSM_OP_LOADA: aluRes = instr.operand;
      default: aluRes = acc_reg;
    endcase
  end

  logic exec;
  logic swWr;
  assign exec = instrValid;
  assign swWr = regWr;

  // ****************************************
  // accumulator
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      acc_reg <= `CSM_RST_BYTE;
    else if (exec && (instr.op != CSM_OP_NONE) && (instr.op != CSM_OP_MOVA)
             && (instr.op != CSM_OP_TABLE_READ_OP) && (instr.op != CSM_OP_TABLE_READ_LASTPAGE_OP))
    begin
      if (instr.op == CSM_OP_MOVM)
        acc_reg <= memRdData;
      else
        acc_reg <= aluRes;
    end
    else if (swWr && regAddr == `CSM_ADDR_ACC)
      acc_reg <= regWrData;
  end

  // ****************************************
  // flag register
  // ****************************************
  logic zeroNow;
  assign zeroNow = (aluRes == 8'h00);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      flags_reg <= `CSM_RST_BYTE;
    else
    begin
      if (swWr && isFlagAddr(regAddr))
      begin
        flags_reg[`CSM_F_SCMP] <= regWrData[`CSM_F_SCMP];
        flags_reg[`CSM_F_CHAIN] <= regWrData[`CSM_F_CHAIN];
        flags_reg[3:0] <= regWrData[3:0];
      end
      else if (exec && (aluArith || aluLogic || instr.op == CSM_OP_RLC || instr.op == CSM_OP_RRC))
      begin
        flags_reg[`CSM_F_CARRY] <= aluCarry;
        flags_reg[`CSM_F_HALF] <= aluHalf;
        flags_reg[`CSM_F_WRAP] <= aluWrap;
        if (aluArith || aluLogic)
        begin
          flags_reg[`CSM_F_ZERO] <= zeroNow;
          flags_reg[`CSM_F_SCMP] <= aluWrap ^ aluRes[7];
        end
        if (instr.op == CSM_OP_SUB)
          flags_reg[`CSM_F_CHAIN] <= zeroNow;
        else if (instr.op == CSM_OP_SBC)
          flags_reg[`CSM_F_CHAIN] <= flags_reg[`CSM_F_CHAIN] & zeroNow;
      end
      // system flags: set wins, halt before kick
      if (sysEv.halt)
        flags_reg[`CSM_F_PDOWN] <= 1'b1;
      else if (sysEv.wdKick)
        flags_reg[`CSM_F_PDOWN] <= 1'b0;
      if (sysEv.wdTimeout)
        flags_reg[`CSM_F_WDEXP] <= 1'b1;
      else if (sysEv.wdKick || sysEv.halt)
        flags_reg[`CSM_F_WDEXP] <= 1'b0;
    end
  end

  // ****************************************
  // table pointers and table read
  // ****************************************
  logic tblRd;
  logic [7:0] tblPage;
  logic [7:0] lastPage;
  assign lastPage = 8'((1 << PAGE_BITS) - 1);
  assign tblRd = exec && (instr.op == CSM_OP_TABLE_READ_OP || instr.op == CSM_OP_TABLE_READ_LASTPAGE_OP);
  assign tblPage = (instr.op == CSM_OP_TABLE_READ_LASTPAGE_OP) ? lastPage : ptrHigh_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ptrLow_reg <= `CSM_RST_BYTE;
      ptrHigh_reg <= `CSM_RST_BYTE;
    end
    else if (swWr)
    begin
      if (regAddr == `CSM_ADDR_TBL_PTR_LOW)
        ptrLow_reg <= regWrData;
      if (regAddr == `CSM_ADDR_TBL_PTR_HIGH)
        ptrHigh_reg <= regWrData;
    end
  end

  logic optHit;
  assign optHit = mapOn_reg && (tblPage == lastPage)
                  && (ptrLow_reg >= `CSM_OPT_BASE);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      resHigh_reg <= `CSM_RST_BYTE;
      memWr_reg <= '0;
    end
    else
    begin
      memWr_reg.valid <= 1'b0;
      if (tblRd)
      begin
        memWr_reg.valid <= 1'b1;
        memWr_reg.addr <= instr.addr;
        if (optHit)
        begin
          resHigh_reg <= {2'b00, optWord[13:8]};
          memWr_reg.data <= optWord[7:0];
        end
        else
        begin
          resHigh_reg <= progWord[15:8];
          memWr_reg.data <= progWord[7:0];
        end
      end
      else if (exec && instr.op == CSM_OP_MOVA)
      begin
        memWr_reg.valid <= 1'b1;
        memWr_reg.addr <= instr.addr;
        memWr_reg.data <= acc_reg;
      end
      else if (swWr && regAddr == `CSM_ADDR_TBL_RES_HIGH)
        resHigh_reg <= regWrData;
    end
  end

  // ****************************************
  // branch low byte
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      branch_reg <= `CSM_RST_BYTE;
      branchTaken_reg <= 1'b0;
      dummy_reg <= 1'b0;
    end
    else
    begin
      branchTaken_reg <= 1'b0;
      dummy_reg <= branchTaken_reg;
      if (swWr && regAddr == `CSM_ADDR_BRANCH_LOW)
      begin
        branch_reg <= regWrData;
        branchTaken_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // option map unlock
  // ****************************************
  logic ulWr;
  logic ulDone;
  assign ulWr = swWr && regAddr == `CSM_ADDR_UNLOCK;
  assign ulDone = ulWr && ulState_reg == CSM_UL_GOT55 && regWrData == `CSM_UNLOCK_SECOND;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      unlock_reg <= `CSM_RST_BYTE;
    else if (sysEv.wake)
      unlock_reg <= `CSM_RST_BYTE;
    else if (ulWr)
      unlock_reg <= regWrData;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ulState_reg <= CSM_UL_IDLE;
    else if (sysEv.wake)
      ulState_reg <= CSM_UL_IDLE;
    else
    begin
      case (ulState_reg)
        CSM_UL_IDLE:
          if (ulWr && regWrData == `CSM_UNLOCK_FIRST)
            ulState_reg <= CSM_UL_GOT55;
        CSM_UL_GOT55:
          if (ulWr && regWrData == `CSM_UNLOCK_FIRST)
            ulState_reg <= CSM_UL_GOT55;
          else
            ulState_reg <= CSM_UL_IDLE;
        default: ulState_reg <= CSM_UL_IDLE;
      endcase
    end
  end

  // window timer counts slow oscillator rising edges
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      oscSync1_reg <= 1'b0;
      oscSync2_reg <= 1'b0;
      oscPrev_reg <= 1'b0;
    end
    else
    begin
      oscSync1_reg <= slowOsc;
      oscSync2_reg <= oscSync1_reg;
      oscPrev_reg <= oscSync2_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mapOn_reg <= 1'b0;
      tick_reg <= 3'h0;
    end
    else if (ulDone)
    begin
      mapOn_reg <= 1'b1;
      tick_reg <= 3'h0;
    end
    else if (mapOn_reg && oscSync2_reg && !oscPrev_reg)
    begin
      if (tick_reg == WINDOW_TICKS - 3'h1)
        mapOn_reg <= 1'b0;
      tick_reg <= tick_reg + 3'h1;
    end
  end

  // ****************************************
  // sector select and register read
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sector_reg <= 2'h0;
    else if (exec && (instr.op == CSM_OP_MOVM || instr.op == CSM_OP_MOVA))
      sector_reg <= {1'b0, instr.addr[`CSM_ADDR_SECTOR_MSB]};
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdData_reg <= `CSM_RST_BYTE;
    else if (regRd)
    begin
      case (regAddr)
        `CSM_ADDR_ACC: rdData_reg <= acc_reg;
        `CSM_ADDR_BRANCH_LOW: rdData_reg <= branch_reg;
        `CSM_ADDR_TBL_PTR_LOW: rdData_reg <= ptrLow_reg;
        `CSM_ADDR_TBL_RES_HIGH: rdData_reg <= resHigh_reg;
        `CSM_ADDR_TBL_PTR_HIGH: rdData_reg <= ptrHigh_reg;
        `CSM_ADDR_FLAGS: rdData_reg <= flags_reg;
        `CSM_ADDR_UNLOCK: rdData_reg <= unlock_reg;
        default: rdData_reg <= `CSM_RST_BYTE;
      endcase
    end
    else
      rdData_reg <= `CSM_RST_BYTE;
  end

  // ****************************************
  // outputs
  // ****************************************
  logic [PAGE_BITS+7:0] tblPtr_reg;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tblPtr_reg <= '0;
    else
      tblPtr_reg <= {ptrHigh_reg[PAGE_BITS-1:0], ptrLow_reg};
  end

  assign regRdData = rdData_reg;
  assign accOut = acc_reg;
  assign flagsOut = flags_reg;
  assign tablePtr = tblPtr_reg;
  assign memWr = memWr_reg;
  assign branchLow = branch_reg;
  assign branchTaken = branchTaken_reg;
  assign dummyCycle = dummy_reg;
  assign optMapActive = mapOn_reg;
  assign sectorSel = sector_reg;

endmodule : csm_core

// file: core/csm_pkg.sv
// types of the core status block
package csm_pkg;

  typedef enum logic [3:0]
  {
    CSM_OP_NONE = 4'h0,
    CSM_OP_ADD = 4'h1,
    CSM_OP_ADC = 4'h2,
    CSM_OP_SUB = 4'h3,
    CSM_OP_SBC = 4'h4,
    CSM_OP_AND = 4'h5,
    CSM_OP_OR = 4'h6,
    CSM_OP_XOR = 4'h7,
    CSM_OP_RLC = 4'h8,
    CSM_OP_RRC = 4'h9,
    CSM_OP_MOVA = 4'hA,
    CSM_OP_TABLE_READ_OP = 4'hB,
    CSM_OP_TABLE_READ_LASTPAGE_OP = 4'hC,
    CSM_OP_MOVM = 4'hD,
    CSM_OP_LOADA = 4'hE
  } csm_op_t;

  typedef struct packed
  {
    csm_op_t op;
    logic [8:0] addr;
    logic [7:0] operand;
  } csm_instr_t;

  typedef struct packed
  {
    logic wdTimeout;
    logic wdKick;
    logic halt;
    logic wake;
  } csm_sys_t;

  typedef struct packed
  {
    logic valid;
    logic [8:0] addr;
    logic [7:0] data;
  } csm_mem_wr_t;

endpackage : csm_pkg

// file: core/csm_regs.svh
// register offsets, reset values and timing counts of the core status block
`ifndef CSM_REGS_SVH
`define CSM_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define CSM_ADDR_ACC 9'h005
`define CSM_ADDR_BRANCH_LOW 9'h006
`define CSM_ADDR_TBL_PTR_LOW 9'h007
`define CSM_ADDR_TBL_RES_HIGH 9'h008
`define CSM_ADDR_TBL_PTR_HIGH 9'h009
`define CSM_ADDR_FLAGS 9'h00A
`define CSM_ADDR_UNLOCK 9'h077
`define CSM_ADDR_SECTOR_MSB 8

// ****************************************
// field positions of the flag register
// ****************************************
`define CSM_F_CARRY 0
`define CSM_F_HALF 1
`define CSM_F_ZERO 2
`define CSM_F_WRAP 3
`define CSM_F_PDOWN 4
`define CSM_F_WDEXP 5
`define CSM_F_CHAIN 6
`define CSM_F_SCMP 7

// ****************************************
// reset values and patterns
// ****************************************
`define CSM_RST_BYTE 8'h00
`define CSM_UNLOCK_FIRST 8'h55
`define CSM_UNLOCK_SECOND 8'hAA
`define CSM_OPT_BASE 8'hC0
`define CSM_OPT_WORDS 64
`define CSM_WINDOW_TICKS 3'h4

`endif
